// >>> src/psd_pkg.sv
// Types shared by the processor status bank
// Assumes psd_regs.svh is on the include path
package psd_pkg;
`include "psd_regs.svh"
   typedef enum logic [2:0] {
      PSD_CAUSE_NONE = 3'h0,
      PSD_CAUSE_HOST = 3'h1,
      PSD_CAUSE_CALL = 3'h2,
      PSD_CAUSE_IBRK = 3'h3,
      PSD_CAUSE_DWATCH = 3'h4,
      PSD_CAUSE_RWATCH = 3'h5
   } psd_cause_t;
   typedef struct packed {
      logic [31:0] savedStatusWord;
      logic [31:0] savedProgramCounter;
      logic [31:0] savedStackPointer;
   } psd_thread_ctx_t;
   typedef struct packed {
      psd_cause_t cause;
      logic [7:0] thread;
      logic [3:0] unitHits;
      logic [31:0] info;
   } psd_debug_event_t;
endpackage : psd_pkg

// >>> src/psd_regs.svh
// Register numbers, field positions and reset values of the status bank
// Assumes inclusion by the package, the property checker and the bench
`ifndef PSD_REGS_SVH
`define PSD_REGS_SVH
`define PSD_OSC_CTRL 8'h06
`define PSD_CORE_CELL 8'h07
`define PSD_CORE_WIRE 8'h08
`define PSD_PERI_CELL 8'h09
`define PSD_PERI_WIRE 8'h0A
`define PSD_MEM_SIZE 8'h0C
`define PSD_DBG_STATUS 8'h10
`define PSD_DBG_PC 8'h11
`define PSD_DBG_SP 8'h12
`define PSD_DBG_CORESEL 8'h13
`define PSD_DBG_REGSEL 8'h14
`define PSD_DBG_CAUSE 8'h15
`define PSD_DBG_INFO 8'h16
`define PSD_DBG_STOP 8'h18
`define PSD_CORE_EN_BIT 1
`define PSD_PERI_EN_BIT 0
`define PSD_OSC_CTRL_RST 2'h0
`define PSD_COUNT_RST 16'h0000
`define PSD_STATUS_WMASK 32'h000006DF
`define PSD_STATUS_ISSUE_BIT 8
`define PSD_REGSEL_W 5
`define PSD_CAUSE_RST 3'h0
`define PSD_STOP_RST 8'h00
`define PSD_MEM_BYTES 32'h00080000
`endif

// >>> src/psd_ring_counter.sv
// One ring-oscillator counter with its enable and read crossing
// Assumes oscClk is a free-running asynchronous ring oscillator
`timescale 1ns/1ns
module psd_ring_counter (
   input wire logic clock, // Tile core clock
   input wire logic oscClk, // Ring oscillator output
   input wire logic enable, // Run request, core clock domain
   output logic [15:0] countOut // Count sampled into core domain
);
   // No reset: counts survive a system reset, power-up value is zero
   logic enSync1_reg = 1'b0;
   logic enSync2_reg = 1'b0;
   logic [15:0] count_reg = `PSD_COUNT_RST;
   logic [15:0] grayCount_reg = `PSD_COUNT_RST;
   logic [15:0] rdSync1_reg = `PSD_COUNT_RST;
   logic [15:0] rdSync2_reg = `PSD_COUNT_RST;

   function automatic logic [15:0] gray2bin(input logic [15:0] g);
      logic [15:0] b;
      b[15] = g[15];
      for (int i = 14; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction : gray2bin

   always_ff @(posedge oscClk) begin
      enSync1_reg <= enable;
      enSync2_reg <= enSync1_reg;
   end

   always_ff @(posedge oscClk) begin
      if (enSync2_reg) begin
         count_reg <= count_reg + 16'h0001;
         grayCount_reg <= (count_reg + 16'h0001)
            ^ ((count_reg + 16'h0001) >> 1);
      end
   end

   // Gray code keeps a moving count coherent in the core domain
   always_ff @(posedge clock) begin
      rdSync1_reg <= grayCount_reg;
      rdSync2_reg <= rdSync1_reg;
   end

   always_ff @(posedge clock) begin
      countOut <= gray2bin(rdSync2_reg);
   end
endmodule : psd_ring_counter

// >>> src/psd_status_bank.sv
// Processor status bank: ring oscillators, memory size, debug state
// Assumes status accesses arrive as single-cycle strobes on the core clock
`timescale 1ns/1ns
// Function
// - Four ring oscillators, started and stopped by control
// - Control bit 1 enables core oscillators
// - Control bit 0 enables peripheral oscillators
// - Oscillators run asynchronously for random bits
// - Counters at 0x07 to 0x0A in order
// - Sixteen-bit counts, upper bits zero, start zero
// - System reset leaves counts untouched
// - Memory size read-only in bits 31:2
// - Debug entry captures saved status word
// - Status bits 10,9,8,7,6 mode fields
// - Status bits 4..0 kernel, handler, event flags
// - Debug entry captures saved program counter
// - Debug entry captures saved stack pointer
// - Operand one holds target core resource id
// - Operand two holds register number bits 4:0
// - Cause field 2:0 encodes debug source
// - Bits 17:16 lowest triggering unit number
// - Bits 15:8 thread number, zero for host
// - Info holds watch address or resource id
// - Stop mask halts threads outside debug
module psd_status_bank (
   input wire logic clock, // Tile core clock
   input wire logic rst_b, // System reset, active low
   input wire logic [7:0] regNum, // Status register number
   input wire logic writeStrobe, // Status write instruction strobe
   input wire logic [31:0] writeData, // Status write data
   input wire logic readStrobe, // Status read instruction strobe
   output logic [31:0] readData, // Status read data, registered
   output logic readValid, // Read data valid, one cycle
   input wire logic debugMode, // Core is in debug mode
   input wire logic debugEntry, // One-cycle pulse on debugger entry
   input wire psd_pkg::psd_thread_ctx_t entryCtx, // Thread state at entry
   input wire psd_pkg::psd_debug_event_t entryEvent, // Entry cause
   input wire logic [3:0] oscClk, // Core cell, core wire, peri cell, wire
   output logic [3:0] oscEnable, // Oscillator run enables
   output logic [7:0] threadStop, // Threads held outside debug mode
   output logic [31:0] debugCoreSelect, // Target core resource id
   output logic [4:0] debugRegSelect // Target register number
);
   import psd_pkg::*;

   logic [1:0] oscCtrl_reg;
   logic [31:0] status_reg;
   logic [31:0] pc_reg;
   logic [31:0] sp_reg;
   logic [31:0] coreSel_reg;
   logic [4:0] regSel_reg;
   logic [2:0] cause_reg;
   logic [1:0] unit_reg;
   logic [7:0] causeThread_reg;
   logic [31:0] info_reg;
   logic [7:0] stop_reg;
   logic [15:0] count [4];
   logic [31:0] readData_next;
   logic debugWrite;

   function automatic logic isWrite(input logic [7:0] num,
                                    input logic [7:0] target);
      return writeStrobe && (num == target);
   endfunction : isWrite

   function automatic logic [1:0] lowestUnit(input logic [3:0] hits);
      logic [1:0] u;
      u = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (hits[i]) begin
            u = 2'(i);
         end
      end
      return u;
   endfunction : lowestUnit

   assign debugWrite = debugMode;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gOsc
         psd_ring_counter uCounter (
            .clock(clock),
            .oscClk(oscClk[g]),
            .enable(oscEnable[g]),
            .countOut(count[g])
         );
      end
   endgenerate

   // Entries 0,1 are core oscillators, 2,3 peripheral
   assign oscEnable = {{2{oscCtrl_reg[`PSD_PERI_EN_BIT]}},
                       {2{oscCtrl_reg[`PSD_CORE_EN_BIT]}}};
   assign threadStop = debugMode ? 8'h00 : stop_reg;
   assign debugCoreSelect = coreSel_reg;
   assign debugRegSelect = regSel_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         oscCtrl_reg <= `PSD_OSC_CTRL_RST;
      end else if (isWrite(regNum, `PSD_OSC_CTRL)) begin
         oscCtrl_reg <= writeData[1:0];
      end
   end

   // Entry capture wins over a debug write in the same cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= 32'h00000000;
         pc_reg <= 32'h00000000;
         sp_reg <= 32'h00000000;
      end else if (debugEntry) begin
         status_reg <= entryCtx.savedStatusWord
            & (`PSD_STATUS_WMASK | 32'h00000100);
         pc_reg <= entryCtx.savedProgramCounter;
         sp_reg <= entryCtx.savedStackPointer;
      end else if (debugWrite) begin
         if (isWrite(regNum, `PSD_DBG_STATUS)) begin
            // Current issue mode bit is read-only
            status_reg <= (writeData & `PSD_STATUS_WMASK)
               | (status_reg & 32'h00000100);
         end
         if (isWrite(regNum, `PSD_DBG_PC)) begin
            pc_reg <= writeData;
         end
         if (isWrite(regNum, `PSD_DBG_SP)) begin
            sp_reg <= writeData;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         coreSel_reg <= 32'h00000000;
         regSel_reg <= 5'h00;
      end else if (debugWrite) begin
         if (isWrite(regNum, `PSD_DBG_CORESEL)) begin
            coreSel_reg <= writeData;
         end
         if (isWrite(regNum, `PSD_DBG_REGSEL)) begin
            regSel_reg <= writeData[4:0];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cause_reg <= `PSD_CAUSE_RST;
         unit_reg <= 2'h0;
         causeThread_reg <= 8'h00;
         info_reg <= 32'h00000000;
      end else if (debugEntry) begin
         cause_reg <= entryEvent.cause;
         case (entryEvent.cause)
            PSD_CAUSE_HOST: begin
               unit_reg <= 2'h0;
               causeThread_reg <= 8'h00;
            end
            PSD_CAUSE_CALL: begin
               unit_reg <= 2'h0;
               causeThread_reg <= entryEvent.thread;
            end
            default: begin
               unit_reg <= lowestUnit(entryEvent.unitHits);
               causeThread_reg <= entryEvent.thread;
            end
         endcase
         if (entryEvent.cause == PSD_CAUSE_DWATCH
             || entryEvent.cause == PSD_CAUSE_RWATCH) begin
            info_reg <= entryEvent.info;
         end
      end else if (debugWrite) begin
         if (isWrite(regNum, `PSD_DBG_CAUSE)) begin
            cause_reg <= writeData[2:0];
            causeThread_reg <= writeData[15:8];
            unit_reg <= writeData[17:16];
         end
         if (isWrite(regNum, `PSD_DBG_INFO)) begin
            info_reg <= writeData;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stop_reg <= `PSD_STOP_RST;
      end else if (debugWrite && isWrite(regNum, `PSD_DBG_STOP)) begin
         stop_reg <= writeData[7:0];
      end
   end

   // Reserved bits and unmapped numbers read as zero
   always_comb begin
      readData_next = 32'h00000000;
      case (regNum)
         `PSD_OSC_CTRL: readData_next = {30'h0, oscCtrl_reg};
         `PSD_CORE_CELL: readData_next = {16'h0, count[0]};
         `PSD_CORE_WIRE: readData_next = {16'h0, count[1]};
         `PSD_PERI_CELL: readData_next = {16'h0, count[2]};
         `PSD_PERI_WIRE: readData_next = {16'h0, count[3]};
         `PSD_MEM_SIZE: readData_next = {`PSD_MEM_BYTES} & 32'hFFFFFFFC;
         `PSD_DBG_STATUS: readData_next = status_reg;
         `PSD_DBG_PC: readData_next = pc_reg;
         `PSD_DBG_SP: readData_next = sp_reg;
         `PSD_DBG_CORESEL: readData_next = coreSel_reg;
         `PSD_DBG_REGSEL: readData_next = {27'h0, regSel_reg};
         `PSD_DBG_CAUSE: readData_next = {14'h0, unit_reg,
                                          causeThread_reg, 5'h0, cause_reg};
         `PSD_DBG_INFO: readData_next = info_reg;
         `PSD_DBG_STOP: readData_next = {24'h0, stop_reg};
         default: readData_next = 32'h00000000;
      endcase
   end

   // Software waits ten cycles after stopping before reading counts
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         readData <= 32'h00000000;
         readValid <= 1'b0;
      end else begin
         readValid <= readStrobe;
         if (readStrobe) begin
            readData <= readData_next;
         end
      end
   end
endmodule : psd_status_bank

// >>> verification/psd_status_bank_properties.sv
// Port checker for the processor status bank
// Assumes binding onto psd_status_bank, single core clock domain
`timescale 1ns/1ns
`include "psd_regs.svh"
module psd_status_bank_properties (
   input wire logic clock, // Core clock
   input wire logic rst_b, // Reset, active low
   input wire logic [7:0] regNum, // Register number
   input wire logic writeStrobe, // Write strobe
   input wire logic [31:0] writeData, // Write data
   input wire logic readStrobe, // Read strobe
   input wire logic [31:0] readData, // Read data
   input wire logic readValid, // Read valid
   input wire logic debugMode, // Debug mode
   input wire logic [3:0] oscEnable, // Oscillator enables
   input wire logic [7:0] threadStop, // Stop mask
   input wire logic [31:0] debugCoreSelect, // Core select
   input wire logic [4:0] debugRegSelect // Register select
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_osc_enable_map: assert property (writeStrobe && regNum == `PSD_OSC_CTRL
      |=> oscEnable == {{2{$past(writeData[0])}}, {2{$past(writeData[1])}}})
      else $error("oscillator enables do not follow control write");
   a_osc_enable_hold: assert property (
      !(writeStrobe && regNum == `PSD_OSC_CTRL) |=> $stable(oscEnable))
      else $error("oscillator enables changed without a write");
   a_count_upper_zero: assert property (readStrobe
      && regNum inside {[8'h07:8'h0A]} |=> readValid && readData[31:16] == 0)
      else $error("counter read has nonzero upper bits");
   a_memsize_read: assert property (readStrobe && regNum == `PSD_MEM_SIZE
      |=> readData == `PSD_MEM_BYTES)
      else $error("memory size read wrong");
   a_ctrl_reserved: assert property (readStrobe && regNum == `PSD_OSC_CTRL
      |=> readData[31:2] == 30'h0)
      else $error("control reserved bits nonzero");
   a_stop_in_debug: assert property (debugMode |-> threadStop == 8'h00)
      else $error("threads stopped in debug mode");
   a_regsel_write: assert property (writeStrobe && debugMode
      && regNum == `PSD_DBG_REGSEL |=> debugRegSelect == $past(writeData[4:0]))
      else $error("register select not written");
   a_coresel_write: assert property (writeStrobe && debugMode
      && regNum == `PSD_DBG_CORESEL |=> debugCoreSelect == $past(writeData))
      else $error("core select not written");
   a_select_locked: assert property (writeStrobe && !debugMode
      |=> $stable(debugRegSelect) && $stable(debugCoreSelect))
      else $error("operand changed outside debug mode");
   cover property (readStrobe && regNum == `PSD_DBG_CAUSE);
   cover property (writeStrobe && debugMode);
   cover property (oscEnable == 4'hF);
endmodule : psd_status_bank_properties
bind psd_status_bank psd_status_bank_properties u_props (.clock(clock),
   .rst_b(rst_b), .regNum(regNum), .writeStrobe(writeStrobe),
   .writeData(writeData), .readStrobe(readStrobe), .readData(readData),
   .readValid(readValid), .debugMode(debugMode), .oscEnable(oscEnable),
   .threadStop(threadStop), .debugCoreSelect(debugCoreSelect),
   .debugRegSelect(debugRegSelect));

// >>> verification/psd_status_bank_tb.sv
// Self-checking bench for the processor status bank
// Assumes psd_pkg and the checker are compiled before it
`timescale 1ns/1ns
`include "psd_regs.svh"
module psd_status_bank_tb;
   import psd_pkg::*;
   logic clock = 0, rst_b = 0, writeStrobe = 0, readStrobe = 0;
   logic debugMode = 0, debugEntry = 0, readValid;
   logic [7:0] regNum = 8'h00, threadStop;
   logic [31:0] writeData = 32'h0, readData, debugCoreSelect, rv, info, sd;
   logic [31:0] seed = 32'h00014085;
   logic [3:0] oscClk = 4'h0, oscEnable;
   logic [4:0] debugRegSelect;
   logic [15:0] cnt [4];
   psd_thread_ctx_t ctx = '0;
   psd_debug_event_t ev = '0;
   int err_count = 0, checks = 0;
   always #20 clock = ~clock;
   // Oscillators free-run at periods unrelated to the core clock
   always #7 oscClk[0] = ~oscClk[0];
   always #9 oscClk[1] = ~oscClk[1];
   always #11 oscClk[2] = ~oscClk[2];
   always #13 oscClk[3] = ~oscClk[3];
   psd_status_bank dut (.clock(clock), .rst_b(rst_b), .regNum(regNum),
      .writeStrobe(writeStrobe), .writeData(writeData),
      .readStrobe(readStrobe), .readData(readData), .readValid(readValid),
      .debugMode(debugMode), .debugEntry(debugEntry), .entryCtx(ctx),
      .entryEvent(ev), .oscClk(oscClk), .oscEnable(oscEnable),
      .threadStop(threadStop), .debugCoreSelect(debugCoreSelect),
      .debugRegSelect(debugRegSelect));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] cause_word(input psd_debug_event_t e);
      logic [1:0] u;
      u = e.unitHits[0] ? 2'h0 : e.unitHits[1] ? 2'h1 :
         e.unitHits[2] ? 2'h2 : 2'h3;
      if (e.cause inside {PSD_CAUSE_HOST, PSD_CAUSE_CALL}) u = 2'h0;
      return {14'h0, u, (e.cause == PSD_CAUSE_HOST) ? 8'h00 : e.thread,
         5'h0, e.cause};
   endfunction : cause_word
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clock);
      regNum = a;
      writeData = d;
      writeStrobe = 1;
      @(negedge clock);
      writeStrobe = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(negedge clock);
      regNum = a;
      readStrobe = 1;
      @(negedge clock);
      readStrobe = 0;
      chk("readValid", 32'h1, {31'h0, readValid});
      rv = readData;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, rv);
   endtask : rchk
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (5000) @(posedge clock);
      err_count++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(negedge clock);
      rst_b = 1;
      rchk(`PSD_OSC_CTRL, 32'h0);
      for (int i = 0; i < 4; i++) rchk(8'h07 + i[7:0], 32'h0);
      rchk(`PSD_DBG_CAUSE, 32'h0);
      rchk(`PSD_MEM_SIZE, `PSD_MEM_BYTES);
      rchk(8'h0B, 32'h0);
      wr(`PSD_OSC_CTRL, 32'hFFFFFFFF);
      rchk(`PSD_OSC_CTRL, 32'h3);
      chk("oscEnable", 32'hF, {28'h0, oscEnable});
      wr(`PSD_OSC_CTRL, 32'h2);
      chk("oscEnable", 32'h3, {28'h0, oscEnable});
      repeat (100) @(negedge clock);
      wr(`PSD_OSC_CTRL, 32'h0);
      repeat (12) @(negedge clock);
      for (int i = 0; i < 4; i++) begin
         rd(8'h07 + i[7:0]);
         cnt[i] = rv[15:0];
         chk("count upper", 32'h0, {16'h0, rv[31:16]});
         rchk(8'h07 + i[7:0], {16'h0, cnt[i]});
         if (i < 2) chk("core count run", 1, {31'h0, cnt[i] != 0});
      end
      rst_b = 0;
      repeat (3) @(negedge clock);
      rst_b = 1;
      for (int i = 0; i < 4; i++) rchk(8'h07 + i[7:0], {16'h0, cnt[i]});
      info = 32'h0;
      for (int c = 1; c <= 5; c++) begin
         seed = lfsr(seed);
         ctx = {seed, lfsr(seed), ~seed};
         ev.cause = psd_cause_t'(c);
         ev.thread = seed[7:0];
         ev.unitHits = (seed[11:8] == 4'h0) ? 4'h8 : seed[11:8];
         ev.info = lfsr(~seed);
         if (c > 3) info = ev.info;
         debugEntry = 1;
         @(negedge clock);
         debugEntry = 0;
         rchk(`PSD_DBG_STATUS, ctx.savedStatusWord & 32'h000007DF);
         rchk(`PSD_DBG_PC, ctx.savedProgramCounter);
         rchk(`PSD_DBG_SP, ctx.savedStackPointer);
         rchk(`PSD_DBG_CAUSE, cause_word(ev));
         rchk(`PSD_DBG_INFO, info);
      end
      debugMode = 1;
      sd = lfsr(seed);
      wr(`PSD_DBG_CORESEL, sd);
      wr(`PSD_DBG_REGSEL, sd);
      wr(`PSD_DBG_STOP, sd);
      wr(`PSD_DBG_STATUS, 32'hFFFFFFFF);
      wr(`PSD_DBG_CAUSE, 32'hFFFFFFFF);
      rchk(`PSD_DBG_CORESEL, sd);
      rchk(`PSD_DBG_REGSEL, sd & 32'h1F);
      chk("debugRegSelect", sd & 32'h1F, {27'h0, debugRegSelect});
      rchk(`PSD_DBG_STOP, sd & 32'hFF);
      rchk(`PSD_DBG_STATUS,
         32'h6DF | (ctx.savedStatusWord & 32'h100));
      rchk(`PSD_DBG_CAUSE, 32'h0003FF07);
      chk("threadStop", 32'h0, {24'h0, threadStop});
      debugMode = 0;
      #1 chk("threadStop", {24'h0, sd[7:0]}, {24'h0, threadStop});
      wr(`PSD_DBG_CORESEL, ~sd);
      wr(`PSD_DBG_STOP, ~sd);
      rchk(`PSD_DBG_CORESEL, sd);
      rchk(`PSD_DBG_STOP, sd & 32'hFF);
      tally_and_finish();
   end
endmodule : psd_status_bank_tb
